// >>> hbppr_top.sv
// Host bus signal layer: phase sampling, even parity generation and check, reset and suspend
// Operation
// - Every bus signal is sampled only on the rising bus clock edge.
// - Bus reset floats all outputs and clears internal registers.
// - No function during bus reset; default state after release.
// - Suspend with bus reset floats outputs but keeps register contents.
// - Address/data lines carry address in address phase, data in data phases.
// - Command/byte-enable lines carry command, then per-lane byte enables.
// - Byte enable n qualifies byte lane n, lowest to highest.
// - Even parity is computed over all address/data and command/enable lines.
// - As initiator, parity is driven one clock after what it covers.
// - As target, mismatching parity asserts the parity-error signal.
// - Parity-error signal is driven low only while reporting is enabled.
`timescale 1ns/100ps
`include "hbppr_defines.svh"
module hbppr_top
  import hbppr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic suspend,
  input wire logic perr_enable,
  input wire logic [`HBPPR_AD_W-1:0] ad_in,
  input wire logic [`HBPPR_CBE_W-1:0] cbe_in,
  input wire logic par_in,
  input wire logic frame_n_in,
  input wire logic irdy_n_in,
  input wire logic trdy_n_in,
  input wire logic tgt_write,
  input wire logic init_drive,
  input wire logic [`HBPPR_AD_W-1:0] init_ad,
  input wire logic [`HBPPR_CBE_W-1:0] init_cbe,
  output logic [`HBPPR_AD_W-1:0] ad_out,
  output logic [`HBPPR_CBE_W-1:0] cbe_out,
  output logic ad_oe,
  output logic cbe_oe,
  output logic par_out,
  output logic par_oe,
  output logic perr_n_out,
  output logic perr_n_oe,
  output logic [`HBPPR_AD_W-1:0] rx_ad,
  output logic [`HBPPR_CBE_W-1:0] rx_cmd,
  output logic [`HBPPR_AD_W-1:0] rx_lane_data,
  output logic rx_addr_phase,
  output logic rx_data_phase,
  output logic perr_event,
  output logic [`HBPPR_CNT_W-1:0] perr_count
);

  hbppr_state_s st;
  hbppr_state_s next_st;
  logic addr_now;
  logic data_now;

  // Even parity: the returned bit makes the total count of ones even
  function automatic logic calc_par(input logic [`HBPPR_AD_W-1:0] ad, input logic [`HBPPR_CBE_W-1:0] cbe);
    calc_par = ^{ad, cbe};
  endfunction : calc_par

  // Byte enables are active low; enable n opens lane n
  function automatic logic [`HBPPR_AD_W-1:0] lane_mask(input logic [`HBPPR_CBE_W-1:0] cbe);
    logic [`HBPPR_AD_W-1:0] m;
    m = `HBPPR_AD_ZERO;
    for (int i = 0; i < `HBPPR_CBE_W; i++) begin
      m[i*`HBPPR_LANE_W +: `HBPPR_LANE_W] = {`HBPPR_LANE_W{~cbe[i]}};
    end
    lane_mask = m;
  endfunction : lane_mask

  always_comb begin
    next_st = st;
    addr_now = (st.bus == HBPPR_IDLE) && !frame_n_in;
    data_now = (st.bus == HBPPR_BUSY) && !irdy_n_in && !trdy_n_in;
    next_st.rx_addr_phase = 1'b0;
    next_st.rx_data_phase = 1'b0;
    next_st.perr_event = 1'b0;
    next_st.chk_pend = 1'b0;
    case (st.bus)
      HBPPR_IDLE: begin
        if (!frame_n_in) begin
          next_st.bus = HBPPR_BUSY;
        end
      end
      HBPPR_BUSY: begin
        if (frame_n_in && (data_now || irdy_n_in)) begin
          next_st.bus = HBPPR_IDLE;
        end
      end
      default: begin
        next_st.bus = HBPPR_IDLE;
      end
    endcase
    if (addr_now) begin
      next_st.rx_ad = ad_in;
      next_st.rx_cbe = cbe_in;
      next_st.rx_cmd = cbe_in;
      next_st.rx_addr_phase = 1'b1;
    end else if (data_now) begin
      next_st.rx_ad = ad_in;
      next_st.rx_cbe = cbe_in;
      next_st.rx_lane_data = ad_in & lane_mask(cbe_in);
      next_st.rx_data_phase = 1'b1;
    end
    // Our own driven phases are not checked; only the far initiator's
    if ((addr_now || (data_now && tgt_write)) && !st.ad_oe) begin
      next_st.chk_pend = 1'b1;
      next_st.chk_par = calc_par(ad_in, cbe_in);
    end
    // Parity for a phase lands one clock after it, so compare against the next PAR
    next_st.perr_n_out = `HBPPR_PERR_IDLE;
    next_st.perr_n_oe = !st.perr_n_out; // Drive high one clock before release
    if (st.chk_pend && (par_in != st.chk_par)) begin
      next_st.perr_event = 1'b1;
      if (st.perr_count != `HBPPR_CNT_MAX) begin
        next_st.perr_count = st.perr_count + `HBPPR_CNT_ONE;
      end
      if (perr_enable) begin
        next_st.perr_n_out = `HBPPR_PERR_ACT;
        next_st.perr_n_oe = 1'b1;
      end
    end
    next_st.ad_oe = init_drive;
    if (init_drive) begin
      next_st.ad_out = init_ad;
      next_st.cbe_out = init_cbe;
    end
    next_st.par_oe = st.ad_oe;
    next_st.par_out = calc_par(st.ad_out, st.cbe_out);
    if (rst) begin
      if (suspend) begin
        // Contents survive; drives, pulses, pending checks and the bus state are dropped
        next_st.bus = HBPPR_IDLE;
        next_st.ad_oe = 1'b0;
        next_st.par_oe = 1'b0;
        next_st.perr_n_oe = 1'b0;
        next_st.perr_n_out = `HBPPR_PERR_IDLE;
        next_st.rx_ad = st.rx_ad;
        next_st.rx_cbe = st.rx_cbe;
        next_st.rx_cmd = st.rx_cmd;
        next_st.rx_lane_data = st.rx_lane_data;
        next_st.ad_out = st.ad_out;
        next_st.cbe_out = st.cbe_out;
        next_st.par_out = st.par_out;
        next_st.chk_par = st.chk_par;
        next_st.perr_count = st.perr_count;
        next_st.chk_pend = 1'b0;
        next_st.perr_event = 1'b0;
        next_st.rx_addr_phase = 1'b0;
        next_st.rx_data_phase = 1'b0;
      end else begin
        next_st = '0;
        next_st.bus = HBPPR_IDLE;
        next_st.perr_n_out = `HBPPR_PERR_IDLE;
      end
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign ad_out = st.ad_out;
  assign cbe_out = st.cbe_out;
  assign ad_oe = st.ad_oe;
  assign cbe_oe = st.ad_oe;
  assign par_out = st.par_out;
  assign par_oe = st.par_oe;
  assign perr_n_out = st.perr_n_out;
  assign perr_n_oe = st.perr_n_oe;
  assign rx_ad = st.rx_ad;
  assign rx_cmd = st.rx_cmd;
  assign rx_lane_data = st.rx_lane_data;
  assign rx_addr_phase = st.rx_addr_phase;
  assign rx_data_phase = st.rx_data_phase;
  assign perr_event = st.perr_event;
  assign perr_count = st.perr_count;

  default clocking cb @(posedge clk); endclocking

  sequence s_phase_checked;
    !rst && !ad_oe && (((st.bus == HBPPR_IDLE) && !frame_n_in) ||
      ((st.bus == HBPPR_BUSY) && !irdy_n_in && !trdy_n_in && tgt_write));
  endsequence
  sequence s_bad_parity;
    !rst && (par_in != $past(calc_par(ad_in, cbe_in))) && perr_enable;
  endsequence
  // Counting must not depend on whether the pin may be driven
  sequence s_par_mismatch;
    !rst && (par_in != $past(calc_par(ad_in, cbe_in)));
  endsequence

  chk_par_follows: assert property (disable iff (rst) ad_oe |=> par_oe &&
      (par_out == calc_par($past(ad_out), $past(cbe_out))))
    else $error("parity not driven one clock after initiator phase");
  chk_par_even: assert property (disable iff (rst) par_oe |->
      (^{par_out, $past(ad_out), $past(cbe_out)}) == 1'b0)
    else $error("driven parity is not even");
  chk_perr_flag: assert property (disable iff (rst) s_phase_checked ##1 s_bad_parity |=>
      perr_n_oe && (perr_n_out == `HBPPR_PERR_ACT) && perr_event)
    else $error("parity mismatch did not assert parity error");
  chk_perr_gated: assert property (disable iff (rst)
      (perr_n_oe && (perr_n_out == `HBPPR_PERR_ACT)) |-> $past(perr_enable))
    else $error("parity error driven while reporting disabled");
  chk_reset_float: assert property (rst |=> !ad_oe && !cbe_oe && !par_oe && !perr_n_oe)
    else $error("output driven during bus reset");
  chk_reset_clear: assert property ((rst && !suspend) |=>
      (perr_count == `HBPPR_CNT_ZERO) && (rx_ad == `HBPPR_AD_ZERO) && (rx_cmd == `HBPPR_CBE_ZERO))
    else $error("registers not cleared by bus reset");
  chk_reset_idle: assert property (rst |=> !rx_addr_phase && !rx_data_phase && !perr_event)
    else $error("activity reported during bus reset");
  chk_suspend_keep: assert property ((rst && suspend) |=>
      $stable(perr_count) && $stable(rx_ad) && $stable(rx_cmd) && !ad_oe)
    else $error("suspend reset altered register contents");
  chk_addr_sample: assert property (disable iff (rst) ((st.bus == HBPPR_IDLE) && !frame_n_in) |=>
      rx_addr_phase && (rx_ad == $past(ad_in)) && (rx_cmd == $past(cbe_in)))
    else $error("address phase not captured");
  chk_lane_data: assert property (disable iff (rst) rx_data_phase |->
      (rx_lane_data[`HBPPR_LANE_W-1:0] ==
      ($past(cbe_in[0]) ? {`HBPPR_LANE_W{1'b0}} : $past(ad_in[`HBPPR_LANE_W-1:0]))))
    else $error("byte lane 0 not qualified by its enable");
  chk_event_ungated: assert property (disable iff (rst) s_phase_checked ##1 s_par_mismatch |=> perr_event)
    else $error("parity mismatch not reported as an event");
  chk_data_sample: assert property (disable iff (rst)
      ((st.bus == HBPPR_BUSY) && !irdy_n_in && !trdy_n_in) |=> rx_data_phase && (rx_ad == $past(ad_in)))
    else $error("data phase not captured");

endmodule : hbppr_top

// >>> hbppr_defines.svh
// Width and constant definitions for the host bus phase, parity and reset block
`ifndef HBPPR_DEFINES_SVH
`define HBPPR_DEFINES_SVH
`define HBPPR_AD_W 32
`define HBPPR_CBE_W 4
`define HBPPR_LANE_W 8
`define HBPPR_CNT_W 8
`define HBPPR_AD_ZERO 32'h0000_0000
`define HBPPR_CBE_ZERO 4'h0
`define HBPPR_CNT_ZERO 8'h00
`define HBPPR_CNT_ONE 8'h01
`define HBPPR_CNT_MAX 8'hff
`define HBPPR_PERR_IDLE 1'b1
`define HBPPR_PERR_ACT 1'b0
`endif

// >>> hbppr_pkg.sv
// Types for the host bus phase, parity and reset block
`include "hbppr_defines.svh"
package hbppr_pkg;
  typedef enum logic {HBPPR_IDLE, HBPPR_BUSY} hbppr_bus_e;
  typedef struct packed {
    hbppr_bus_e bus;
    logic [`HBPPR_AD_W-1:0] rx_ad;
    logic [`HBPPR_CBE_W-1:0] rx_cbe;
    logic [`HBPPR_CBE_W-1:0] rx_cmd;
    logic [`HBPPR_AD_W-1:0] rx_lane_data;
    logic rx_addr_phase;
    logic rx_data_phase;
    logic chk_pend;
    logic chk_par;
    logic [`HBPPR_AD_W-1:0] ad_out;
    logic [`HBPPR_CBE_W-1:0] cbe_out;
    logic ad_oe;
    logic par_out;
    logic par_oe;
    logic perr_n_out;
    logic perr_n_oe;
    logic perr_event;
    logic [`HBPPR_CNT_W-1:0] perr_count;
  } hbppr_state_s;
endpackage : hbppr_pkg

// >>> hbppr_host_model.sv
// Bus agent that starts transfers toward the block
`timescale 1ns/100ps
module hbppr_host_model
  import hbppr_pkg::*;
(
  input wire logic clk,
  output logic [31:0] ad,
  output logic [3:0] cbe,
  output logic par,
  output logic frame_n,
  output logic irdy_n,
  output logic trdy_n
);
  initial begin
    {ad, cbe, par} = 37'h0;
    {frame_n, irdy_n, trdy_n} = 3'h7;
  end
  // Drives at the falling edge, the block samples at the rising one
  task automatic xfer(input logic [31:0] a, d, input logic [3:0] c, e, input logic bad, input int w);
    @(negedge clk);
    frame_n = 1'b0;
    ad = a;
    cbe = c;
    @(negedge clk);
    par = ^{a, c} ^ bad;
    ad = d;
    cbe = e;
    repeat (w) @(negedge clk);
    frame_n = 1'b1;
    {irdy_n, trdy_n} = 2'h0;
    @(negedge clk);
    par = ^{d, e};
    {irdy_n, trdy_n} = 2'h3;
    // Released lines must not look like held data
    ad = ~d;
    cbe = ~e;
  endtask : xfer
  task automatic rel;
    @(negedge clk);
    par = ~par;
  endtask : rel
endmodule : hbppr_host_model

// >>> hbppr_top_tb.sv
// Self-checking bench for the host bus phase, parity and reset block
`timescale 1ns/100ps
module hbppr_top_tb
  import hbppr_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, suspend = 1'b0, perr_enable = 1'b1, tgt_write = 1'b1, init_drive = 1'b0;
  logic [31:0] init_ad = 32'h0, h_ad, ad_in, ad_out, rx_ad, rx_lane_data;
  logic [3:0] init_cbe = 4'h0, h_cbe, cbe_in, cbe_out, rx_cmd;
  logic h_par, par_in, frame_n_in, irdy_n_in, trdy_n_in, ad_oe, cbe_oe, par_out, par_oe, perr_n_out, perr_n_oe;
  logic rx_addr_phase, rx_data_phase, perr_event;
  logic [7:0] perr_count;
  int mismatches = 0, n_checks = 0;
  always #2.5 clk = ~clk;
  // Shared wire: whoever enables drives it
  assign ad_in = ad_oe ? ad_out : h_ad;
  assign cbe_in = cbe_oe ? cbe_out : h_cbe;
  assign par_in = par_oe ? par_out : h_par;
  hbppr_host_model host (.clk, .ad(h_ad), .cbe(h_cbe), .par(h_par), .frame_n(frame_n_in), .irdy_n(irdy_n_in),
    .trdy_n(trdy_n_in));
  hbppr_top uut (.clk, .rst, .suspend, .perr_enable, .ad_in, .cbe_in, .par_in, .frame_n_in, .irdy_n_in, .trdy_n_in,
    .tgt_write, .init_drive, .init_ad, .init_cbe, .ad_out, .cbe_out, .ad_oe, .cbe_oe, .par_out, .par_oe,
    .perr_n_out, .perr_n_oe, .rx_ad, .rx_cmd, .rx_lane_data, .rx_addr_phase, .rx_data_phase, .perr_event,
    .perr_count);
  task automatic cmp(input string what, input logic [31:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic t_target(input logic [31:0] a, d, input logic [3:0] c, e, input int w);
    logic [31:0] m;
    logic [7:0] n;
    n = perr_count;
    for (int i = 0; i < 4; i++)
      m[8*i+:8] = {8{~e[i]}};
    host.xfer(a, d, c, e, 1'b0, w);
    tick;
    cmp("rx_cmd", c, rx_cmd);
    cmp("rx_ad", d, rx_ad);
    cmp("rx_lane_data", d & m, rx_lane_data);
    host.rel;
    tick;
    cmp("perr_count", n, perr_count);
    cmp("perr_n_oe", 1'b0, perr_n_oe);
  endtask : t_target
  task automatic t_perr(input logic en);
    logic [7:0] n;
    n = perr_count;
    @(negedge clk);
    perr_enable = en;
    host.xfer(32'h0000_1000, 32'h1234_5678, 4'h6, 4'h0, 1'b1, 0);
    // The error pulse stands only until the next rising edge
    cmp("perr_event", 1'b1, perr_event);
    cmp("rx_data_phase", 1'b1, rx_data_phase);
    cmp("perr_n_oe", en, perr_n_oe);
    if (en) cmp("perr_n_out", 1'b0, perr_n_out);
    cmp("perr_count", n + 8'h01, perr_count);
    host.rel;
  endtask : t_perr
  task automatic t_init;
    @(negedge clk);
    init_drive = 1'b1;
    init_ad = 32'ha5c3_0f96;
    init_cbe = 4'h7;
    @(negedge clk);
    init_drive = 1'b0;
    cmp("ad_out", 32'ha5c3_0f96, ad_out);
    cmp("ad_oe", 1'b1, ad_oe);
    cmp("cbe_out", 4'h7, cbe_out);
    cmp("cbe_oe", 1'b1, cbe_oe);
    cmp("par_oe", 1'b0, par_oe);
    tick;
    cmp("par_out", ^{32'ha5c3_0f96, 4'h7}, par_out);
    cmp("par_oe", 1'b1, par_oe);
    cmp("ad_oe", 1'b0, ad_oe);
  endtask : t_init
  task automatic t_suspend;
    logic [7:0] n;
    logic [31:0] a;
    n = perr_count;
    a = rx_ad;
    @(negedge clk);
    suspend = 1'b1;
    rst = 1'b1;
    tick;
    cmp("perr_count", n, perr_count);
    cmp("rx_ad", a, rx_ad);
    cmp("ad_oe", 1'b0, ad_oe);
    @(negedge clk);
    suspend = 1'b0;
    tick;
    cmp("perr_count", 8'h00, perr_count);
    cmp("rx_lane_data", 32'h0, rx_lane_data);
    @(negedge clk);
    rst = 1'b0;
  endtask : t_suspend
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    cmp("perr_n_oe", 1'b0, perr_n_oe);
    cmp("perr_count", 8'h00, perr_count);
    t_target(32'h0000_2000, 32'hdead_beef, 4'h7, 4'h5, 0);
    t_target(32'h0000_2004, 32'h0bad_cafe, 4'h6, 4'ha, 2);
    t_perr(1'b1);
    t_perr(1'b0);
    t_init;
    t_suspend;
    t_target(32'h0000_3000, 32'h8001_7ffe, 4'h7, 4'h0, 0);
    end_sim;
  end
  initial begin
    #2000;
    mismatches++;
    end_sim;
  end
endmodule : hbppr_top_tb
